//--- verilog/sgf_switch_global_forwarding_control.sv
// Global forwarding control registers and the policy logic they steer.
// Assumes a synchronous one-cycle register port and synchronous frame inputs.
// Overview of operation
// - With size check disabled, frames up to 1536 bytes are accepted.
// - Else drop tagged over 1522, untagged over 1518; special-tagged frames use the 1518 limit.
// - Bit 7 of the forwarding register turns 802.1q VLAN handling on or off.
// - IGMP snoop bit 6 sends every IGMP frame to the host port.
// - Direct mode bit 5 steers host frames by preamble, bypassing lookup.
// - Pre-tag bit 4 prefixes host-bound frames with the source port number.
// - Tag mask bit 1, with VLAN bit 7 clear, uses the low 5 VID bits as the destination port mask.
// - Sniff select set mirrors only when source and destination both match.
// - Sniff select clear mirrors when source or destination matches.
// - Host port register bit 7 enables half-duplex back pressure.
// - Host port register bit 6 selects half duplex if set, full if clear.
// - The duplex bit loads from the strap pin on the first clock after reset, low meaning full.
// - Huge packet support accepts up to 1916 bytes, overriding size check.
`timescale 1ns/100ps
`default_nettype none
module sgf_switch_global_forwarding_control
    import sgf_pkg::*;
#(
    parameter int PORTS = 5
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_duplex_strap_pin,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_frm_valid,
    input wire logic [10:0] i_frm_len,
    input wire logic i_frm_tagged,
    input wire logic i_frm_special_tag,
    input wire logic i_frm_igmp,
    input wire logic [11:0] i_frm_vid,
    input wire logic [PORTS-1:0] i_frm_src,
    input wire logic [PORTS-1:0] i_frm_lookup_dst,
    input wire logic [PORTS-1:0] i_frm_preamble_dst,
    input wire logic [PORTS-1:0] i_sniff_ports,
    input wire logic [PORTS-1:0] i_host_port,
    output logic o_frm_drop,
    output logic [PORTS-1:0] o_frm_dst,
    output logic o_frm_mirror,
    output logic o_frm_pretag,
    output logic o_vlan_en,
    output logic o_host_bp_en,
    output logic o_host_half_duplex
);
    default clocking sgf_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] policy;
        logic [7:0] fwd;
        logic [7:0] host;
        logic strap_done;
        logic [7:0] rdata;
        logic drop;
        logic [PORTS-1:0] dst;
        logic mirror;
        logic pretag;
    } sgf_state_t;

    sgf_state_t st_q;
    sgf_state_t st_d;
    logic [10:0] max_len;
    logic [PORTS-1:0] dst_sel;
    logic src_hit;
    logic dst_hit;
    logic to_host;

    // ************************************************************
    // Frame policy
    // ************************************************************
    always_comb begin
        if (st_q.policy[SGF_BIT_HUGE_PKT]) begin
            max_len = SGF_LEN_HUGE;
        end else if (st_q.policy[SGF_BIT_SIZE_CHECK_DIS]) begin
            max_len = SGF_LEN_NO_CHECK;
        end else if (i_frm_tagged && !i_frm_special_tag) begin
            max_len = SGF_LEN_TAGGED;
        end else begin
            max_len = SGF_LEN_UNTAGGED;
        end
        if (st_q.fwd[SGF_BIT_DIRECT_MODE] && (i_frm_src == i_host_port)) begin
            dst_sel = i_frm_preamble_dst;
        end else if (st_q.fwd[SGF_BIT_TAG_MASK]
                     && !st_q.fwd[SGF_BIT_VLAN_EN] && i_frm_tagged) begin
            dst_sel = i_frm_vid[PORTS-1:0];
        end else begin
            dst_sel = i_frm_lookup_dst;
        end
        if (st_q.fwd[SGF_BIT_IGMP_SNOOP] && i_frm_igmp) begin
            dst_sel = i_host_port;
        end
        src_hit = |(i_frm_src & i_sniff_ports);
        dst_hit = |(dst_sel & i_sniff_ports);
        to_host = |(dst_sel & i_host_port);
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        if (!st_q.strap_done) begin
            st_d.host[SGF_BIT_HOST_HALF_DUPLEX] = i_duplex_strap_pin;
            st_d.strap_done = 1'b1;
        end else if (i_reg_wr) begin
            unique case (i_reg_addr)
                SGF_ADDR_FRAME_POLICY:
                    st_d.policy = i_reg_wdata & SGF_MASK_FRAME_POLICY;
                SGF_ADDR_FORWARDING:
                    st_d.fwd = i_reg_wdata & SGF_MASK_FORWARDING;
                SGF_ADDR_HOST_PORT:
                    st_d.host = i_reg_wdata & SGF_MASK_HOST_PORT;
                default: ;
            endcase
        end
        unique case (i_reg_addr)
            SGF_ADDR_FRAME_POLICY: st_d.rdata = st_d.policy;
            SGF_ADDR_FORWARDING: st_d.rdata = st_d.fwd;
            SGF_ADDR_HOST_PORT: st_d.rdata = st_d.host;
            default: st_d.rdata = 8'h00;
        endcase
        st_d.drop = i_frm_valid && (i_frm_len > max_len);
        st_d.dst = i_frm_valid ? dst_sel : '0;
        if (st_q.fwd[SGF_BIT_SNIFF_AND]) begin
            st_d.mirror = i_frm_valid && src_hit && dst_hit;
        end else begin
            st_d.mirror = i_frm_valid && (src_hit || dst_hit);
        end
        st_d.pretag = i_frm_valid && to_host
                      && st_q.fwd[SGF_BIT_PRE_TAG];
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '{policy: SGF_RST_FRAME_POLICY, fwd: SGF_RST_FORWARDING,
                      host: SGF_RST_HOST_PORT, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_reg_rdata = st_q.rdata;
    assign o_frm_drop = st_q.drop;
    assign o_frm_dst = st_q.dst;
    assign o_frm_mirror = st_q.mirror;
    assign o_frm_pretag = st_q.pretag;
    assign o_vlan_en = st_q.fwd[SGF_BIT_VLAN_EN];
    assign o_host_bp_en = st_q.host[SGF_BIT_HOST_BP_EN];
    assign o_host_half_duplex = st_q.host[SGF_BIT_HOST_HALF_DUPLEX];

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_strap_edge;
        !st_q.strap_done;
    endsequence

    sequence s_strap_loaded;
        o_host_half_duplex == $past(i_duplex_strap_pin);
    endsequence

    sequence s_fwd_write;
        i_reg_wr && st_q.strap_done && i_reg_addr == SGF_ADDR_FORWARDING;
    endsequence

    sequence s_host_write;
        i_reg_wr && st_q.strap_done && i_reg_addr == SGF_ADDR_HOST_PORT;
    endsequence

    AST_STRAP: assert property (s_strap_edge |=> s_strap_loaded)
        else $error("duplex strap not loaded");
    AST_SIZE_NOCHECK: assert property (
        (i_frm_valid && !st_q.policy[SGF_BIT_HUGE_PKT]
         && st_q.policy[SGF_BIT_SIZE_CHECK_DIS]
         && i_frm_len == SGF_LEN_NO_CHECK) |=> !o_frm_drop)
        else $error("1536 byte frame dropped");
    AST_SIZE_TAGGED: assert property (
        (i_frm_valid && st_q.policy[2:1] == 2'b00 && i_frm_tagged
         && !i_frm_special_tag)
        |=> o_frm_drop == ($past(i_frm_len) > SGF_LEN_TAGGED))
        else $error("tagged limit wrong");
    AST_SIZE_UNTAGGED: assert property (
        (i_frm_valid && st_q.policy[2:1] == 2'b00 && !i_frm_tagged)
        |=> o_frm_drop == ($past(i_frm_len) > SGF_LEN_UNTAGGED))
        else $error("untagged limit wrong");
    AST_HUGE: assert property (
        (i_frm_valid && st_q.policy[SGF_BIT_HUGE_PKT])
        |=> o_frm_drop == ($past(i_frm_len) > SGF_LEN_HUGE))
        else $error("huge limit wrong");
    AST_IGMP: assert property (
        (i_frm_valid && i_frm_igmp && st_q.fwd[SGF_BIT_IGMP_SNOOP])
        |=> o_frm_dst == $past(i_host_port))
        else $error("igmp not sent to host");
    AST_SNIFF_AND: assert property (
        (i_frm_valid && st_q.fwd[SGF_BIT_SNIFF_AND] && !src_hit)
        |=> !o_frm_mirror)
        else $error("and sniff mirrored");
    AST_SNIFF_OR: assert property (
        (i_frm_valid && !st_q.fwd[SGF_BIT_SNIFF_AND] && src_hit)
        |=> o_frm_mirror)
        else $error("or sniff missed");
    AST_PRETAG: assert property (
        o_frm_pretag |-> $past(st_q.fwd[SGF_BIT_PRE_TAG]))
        else $error("pretag without mode");
    AST_RSVD_POLICY: assert property (
        (i_reg_addr == SGF_ADDR_FRAME_POLICY)
        |=> (o_reg_rdata & ~SGF_MASK_FRAME_POLICY) == 8'h00)
        else $error("reserved policy bit read nonzero");
    AST_RESERVED: assert property (
        (i_reg_addr == SGF_ADDR_FORWARDING)
        |=> (o_reg_rdata & ~SGF_MASK_FORWARDING) == 8'h00)
        else $error("reserved forwarding bit read nonzero");
    AST_RSVD_HOST: assert property (
        (i_reg_addr == SGF_ADDR_HOST_PORT)
        |=> (o_reg_rdata & ~SGF_MASK_HOST_PORT) == 8'h00)
        else $error("reserved host bit read nonzero");
    AST_DIRECT: assert property (
        (i_frm_valid && st_q.fwd[SGF_BIT_DIRECT_MODE]
         && !(i_frm_igmp && st_q.fwd[SGF_BIT_IGMP_SNOOP])
         && i_frm_src == i_host_port)
        |=> o_frm_dst == $past(i_frm_preamble_dst))
        else $error("direct mode ignored");
    AST_TAG_MASK: assert property (
        (i_frm_valid && i_frm_tagged && st_q.fwd[SGF_BIT_TAG_MASK]
         && !st_q.fwd[SGF_BIT_VLAN_EN] && !st_q.fwd[SGF_BIT_DIRECT_MODE]
         && !(i_frm_igmp && st_q.fwd[SGF_BIT_IGMP_SNOOP]))
        |=> o_frm_dst == $past(i_frm_vid[PORTS-1:0]))
        else $error("tag mask ignored");
    AST_VLAN_EN: assert property (
        s_fwd_write |=> o_vlan_en == $past(i_reg_wdata[SGF_BIT_VLAN_EN]))
        else $error("vlan enable not written");
    AST_HOST_MODE: assert property (
        s_host_write |=> {o_host_bp_en, o_host_half_duplex}
        == $past(i_reg_wdata[7:6]))
        else $error("host port mode not written");
endmodule
`default_nettype wire

//--- verilog/sgf_pkg.sv
// Constants for the global forwarding control register bank.
// Assumes an 8-bit register port with a byte address from the management path.
`default_nettype none
package sgf_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] SGF_ADDR_FRAME_POLICY = 8'h04;
    localparam logic [7:0] SGF_ADDR_FORWARDING = 8'h05;
    localparam logic [7:0] SGF_ADDR_HOST_PORT = 8'h06;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SGF_BIT_UCAST_VLAN_DISCARD = 7;
    localparam int SGF_BIT_MCAST_STORM_DIS = 6;
    localparam int SGF_BIT_BP_MODE = 5;
    localparam int SGF_BIT_FAIR_MODE = 4;
    localparam int SGF_BIT_NO_EXC_COLL_DROP = 3;
    localparam int SGF_BIT_HUGE_PKT = 2;
    localparam int SGF_BIT_SIZE_CHECK_DIS = 1;
    localparam int SGF_BIT_VLAN_EN = 7;
    localparam int SGF_BIT_IGMP_SNOOP = 6;
    localparam int SGF_BIT_DIRECT_MODE = 5;
    localparam int SGF_BIT_PRE_TAG = 4;
    localparam int SGF_BIT_TAG_MASK = 1;
    localparam int SGF_BIT_SNIFF_AND = 0;
    localparam int SGF_BIT_HOST_BP_EN = 7;
    localparam int SGF_BIT_HOST_HALF_DUPLEX = 6;
    // ************************************************************
    // Writable masks and reset values
    // ************************************************************
    localparam logic [7:0] SGF_MASK_FRAME_POLICY = 8'hFE;
    localparam logic [7:0] SGF_MASK_FORWARDING = 8'hF3;
    localparam logic [7:0] SGF_MASK_HOST_PORT = 8'hC0;
    localparam logic [7:0] SGF_RST_FRAME_POLICY = 8'hF0;
    localparam logic [7:0] SGF_RST_FORWARDING = 8'h00;
    localparam logic [7:0] SGF_RST_HOST_PORT = 8'h00;
    // ************************************************************
    // Frame size limits in bytes
    // ************************************************************
    localparam logic [10:0] SGF_LEN_UNTAGGED = 11'h5EE;
    localparam logic [10:0] SGF_LEN_TAGGED = 11'h5F2;
    localparam logic [10:0] SGF_LEN_NO_CHECK = 11'h600;
    localparam logic [10:0] SGF_LEN_HUGE = 11'h77C;
endpackage
`default_nettype wire

//--- sim/tb_top.sv
// Testbench for the global forwarding control register bank.
// Assumes the design package and module are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sgf_pkg::*;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_duplex_strap_pin = 1'b1;
    logic i_reg_wr = 1'b0, i_frm_valid = 1'b0;
    logic i_frm_tagged = 1'b0, i_frm_special_tag = 1'b0, i_frm_igmp = 1'b0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
    logic [10:0] i_frm_len = 11'h040;
    logic [11:0] i_frm_vid = 12'h000;
    logic [4:0] i_frm_src = 5'h01, i_frm_lookup_dst = 5'h02;
    logic [4:0] i_frm_preamble_dst = 5'h0C, i_sniff_ports = 5'h01;
    logic [4:0] i_host_port = 5'h10, o_frm_dst;
    logic o_frm_drop, o_frm_mirror, o_frm_pretag;
    logic o_vlan_en, o_host_bp_en, o_host_half_duplex;
    int num_errors = 0, checks_done = 0;
    logic [10:0] lens[11] = '{11'h5EE, 11'h5EF, 11'h5F2, 11'h5F3, 11'h5EF,
        11'h600, 11'h601, 11'h5F3, 11'h77C, 11'h77D, 11'h601};
    logic [7:0] pols[11] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF2, 8'hF2,
        8'hF2, 8'hF6, 8'hF6, 8'hF4};
    logic [2:0] kinds[11] = '{3'h0, 3'h0, 3'h2, 3'h2, 3'h6, 3'h2, 3'h0,
        3'h2, 3'h0, 3'h0, 3'h0};
    logic drops[11] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0,
        1'b0, 1'b1, 1'b0};
    logic [7:0] masks[4] = '{8'hFE, 8'hF3, 8'hC0, 8'h00};
    sgf_switch_global_forwarding_control #(.PORTS(5)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_duplex_strap_pin(i_duplex_strap_pin), .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_frm_valid(i_frm_valid),
        .i_frm_len(i_frm_len), .i_frm_tagged(i_frm_tagged),
        .i_frm_special_tag(i_frm_special_tag), .i_frm_igmp(i_frm_igmp),
        .i_frm_vid(i_frm_vid), .i_frm_src(i_frm_src),
        .i_frm_lookup_dst(i_frm_lookup_dst),
        .i_frm_preamble_dst(i_frm_preamble_dst),
        .i_sniff_ports(i_sniff_ports), .i_host_port(i_host_port),
        .o_frm_drop(o_frm_drop), .o_frm_dst(o_frm_dst),
        .o_frm_mirror(o_frm_mirror), .o_frm_pretag(o_frm_pretag),
        .o_vlan_en(o_vlan_en), .o_host_bp_en(o_host_bp_en),
        .o_host_half_duplex(o_host_half_duplex));
    always #10 i_sys_clk = ~i_sys_clk;
    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_sys_clk);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_sys_clk);
        i_reg_addr = a;
        @(negedge i_sys_clk);
        chk("reg_rdata", e, o_reg_rdata);
    endtask
    task automatic frm(input logic [10:0] len, input logic [2:0] k);
        @(negedge i_sys_clk);
        {i_frm_special_tag, i_frm_tagged, i_frm_igmp} = k;
        i_frm_len = len;
        i_frm_valid = 1'b1;
        @(negedge i_sys_clk);
        i_frm_valid = 1'b0;
    endtask
    task automatic fx(input logic [7:0] fw, input logic [2:0] k,
        input logic [4:0] dst, input logic mir, input logic pt);
        wr(SGF_ADDR_FORWARDING, fw);
        frm(11'h040, k);
        chk("frm_drop", 8'h00, {7'h00, o_frm_drop});
        chk("frm_dst", {3'h0, dst}, {3'h0, o_frm_dst});
        chk("frm_mirror", {7'h00, mir}, {7'h00, o_frm_mirror});
        chk("frm_pretag", {7'h00, pt}, {7'h00, o_frm_pretag});
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (12) @(negedge i_sys_clk);
        i_rst = 1'b0;
        rd(SGF_ADDR_FRAME_POLICY, SGF_RST_FRAME_POLICY);
        rd(SGF_ADDR_FORWARDING, 8'h00);
        rd(SGF_ADDR_HOST_PORT, 8'h40);
        chk("half_duplex", 8'h01, {7'h00, o_host_half_duplex});
        for (int i = 0; i < 4; i++) begin
            wr(8'h04 + 8'(i), 8'hFF);
            rd(8'h04 + 8'(i), masks[i]);
        end
        chk("vlan_en", 8'h01, {7'h00, o_vlan_en});
        chk("host_bp_en", 8'h01, {7'h00, o_host_bp_en});
        wr(SGF_ADDR_HOST_PORT, 8'h00);
        chk("half_duplex", 8'h00, {7'h00, o_host_half_duplex});
        chk("host_bp_en", 8'h00, {7'h00, o_host_bp_en});
        wr(SGF_ADDR_FORWARDING, 8'h00);
        chk("vlan_en", 8'h00, {7'h00, o_vlan_en});
        for (int i = 0; i < 11; i++) begin
            wr(SGF_ADDR_FRAME_POLICY, pols[i]);
            frm(lens[i], kinds[i]);
            chk("frm_drop", 8'(drops[i]), 8'(o_frm_drop));
        end
        fx(8'h00, 3'h0, 5'h02, 1'b1, 1'b0);
        fx(8'h01, 3'h0, 5'h02, 1'b0, 1'b0);
        i_sniff_ports = 5'h03;
        fx(8'h01, 3'h0, 5'h02, 1'b1, 1'b0);
        i_sniff_ports = 5'h02;
        fx(8'h00, 3'h0, 5'h02, 1'b1, 1'b0);
        i_sniff_ports = 5'h00;
        fx(8'h50, 3'h1, 5'h10, 1'b0, 1'b1);
        fx(8'h10, 3'h0, 5'h02, 1'b0, 1'b0);
        fx(8'h00, 3'h1, 5'h02, 1'b0, 1'b0);
        i_frm_vid = 12'h035;
        fx(8'h02, 3'h2, 5'h15, 1'b0, 1'b0);
        fx(8'h82, 3'h2, 5'h02, 1'b0, 1'b0);
        i_frm_src = 5'h10;
        fx(8'h20, 3'h0, 5'h0C, 1'b0, 1'b0);
        fx(8'h00, 3'h0, 5'h02, 1'b0, 1'b0);
        wr(SGF_ADDR_HOST_PORT, 8'hC0);
        wr(SGF_ADDR_FORWARDING, 8'hFF);
        wr(SGF_ADDR_FRAME_POLICY, 8'h00);
        @(negedge i_sys_clk);
        i_rst = 1'b1;
        i_duplex_strap_pin = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        i_rst = 1'b0;
        rd(SGF_ADDR_HOST_PORT, 8'h00);
        rd(SGF_ADDR_FORWARDING, SGF_RST_FORWARDING);
        rd(SGF_ADDR_FRAME_POLICY, SGF_RST_FRAME_POLICY);
        chk("half_duplex", 8'h00, {7'h00, o_host_half_duplex});
        chk("host_bp_en", 8'h00, {7'h00, o_host_bp_en});
        chk("vlan_en", 8'h00, {7'h00, o_vlan_en});
        end_of_test();
    end
endmodule
`default_nettype wire
